// ---- pkg/prc_defs.vh ----
// Behaviour
// R1: Reset sequence runs at power-on and management reset
// R2: Reserved fine-reset bits accept zero writes harmlessly
// R3: Bit 3 holds masked channels in receive-digital reset
// R4: Bit 2 holds masked receive analog in reset
// R5: Bit 1 holds masked channels in transmit-digital reset
// R6: Bit 0 powers down transmit synthesizer
// R7: Software holds power-down one millisecond before clearing
// R8: Loopback bit n puts channel n in loopback
// R9: Signal-present bit n mirrors channel n detector
// R10: Data-lock control bit forces channel lock to data
// R11: Reference-lock control bit forces channel lock to reference
// R12: Data-locked status shows channel locked to data
// R13: Reference-locked status shows channel locked to reference
// R14: Selector steers coding-layer accesses to lane or group
// R15: Selector means group when bonded, lane otherwise; here bonded reads as lane until the reset sequence is done
// R16: Coding status reports word aligner slip count
// R17: Receive coding bit 0 shows receive FIFO error
// R18: Transmit coding bit 0 shows transmit FIFO error
// R19: Channel reset mask resets to all ones; here the mask is the channel_reset_mask input, with no register
// R20: Management reset is active high, level, whole block
// R21: Unused channel bits and reserved fields read zero
`ifndef PRC_DEFS_VH
`define PRC_DEFS_VH
// Word addresses
`define PRC_ADDR_CHAN_MASK    9'h041
`define PRC_ADDR_MAN_RESET    9'h044
`define PRC_ADDR_LOOPBACK     9'h061
`define PRC_ADDR_SIG_PRESENT  9'h063
`define PRC_ADDR_FORCE_DATA   9'h064
`define PRC_ADDR_FORCE_REF    9'h065
`define PRC_ADDR_DATA_LOCKED  9'h066
`define PRC_ADDR_REF_LOCKED   9'h067
`define PRC_ADDR_LANE_SEL     9'h080
`define PRC_ADDR_RX_CODING    9'h081
`define PRC_ADDR_TX_CODING    9'h082
// Manual reset field positions
`define PRC_BIT_RX_DIGITAL    3
`define PRC_BIT_RX_ANALOG     2
`define PRC_BIT_TX_DIGITAL    1
`define PRC_BIT_SYNTH_PDN     0
`define PRC_MAN_RESET_W       4
// Coding status fields
`define PRC_SLIP_LSB          1
`define PRC_SLIP_W            5
`define PRC_FIFO_ERR_BIT      0
// Reset values
`define PRC_MAN_RESET_RST     4'h0
`define PRC_CHAN_REG_RST      32'h00000000
`define PRC_CHAN_MASK_RST     32'hFFFFFFFF
// Automatic reset sequence timing, in ns and cycles at 50 MHz
`define PRC_CLK_PERIOD_NS     20
`define PRC_SEQ_PDN_NS        1000000
`define PRC_SEQ_PDN_CYC       (`PRC_SEQ_PDN_NS / `PRC_CLK_PERIOD_NS)
`define PRC_SEQ_STEP_NS       1000
`define PRC_SEQ_STEP_CYC      (`PRC_SEQ_STEP_NS / `PRC_CLK_PERIOD_NS)
`endif

// ---- verilog/prc_chan_gate.v ----
`timescale 1ns/1ps
`default_nettype none
// One channel's reset outputs: manual gated by the mask, or automatic
module prc_chan_gate (
    input  wire clk,
    input  wire sys_rst,
    input  wire mask_bit,
    input  wire man_rx_dig,
    input  wire man_rx_ana,
    input  wire man_tx_dig,
    input  wire seq_rx_dig,
    input  wire seq_rx_ana,
    input  wire seq_tx_dig,
    output reg  rx_dig_rst_reg,
    output reg  rx_ana_rst_reg,
    output reg  tx_dig_rst_reg
);
    // Registered so the pins come straight from flops
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_dig_rst_reg <= 1'b1;
            rx_ana_rst_reg <= 1'b1;
            tx_dig_rst_reg <= 1'b1;
        end else begin
            // R3: masked receive digital
            rx_dig_rst_reg <= seq_rx_dig | (man_rx_dig & mask_bit);
            // R4: masked receive analog
            rx_ana_rst_reg <= seq_rx_ana | (man_rx_ana & mask_bit);
            // R5: masked transmit digital
            tx_dig_rst_reg <= seq_tx_dig | (man_tx_dig & mask_bit);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/prc_reset_seq.v ----
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
// Standard reset sequence: synth power-down, then tx digital, rx analog, rx digital release
module prc_reset_seq #(
    parameter PDN_CYC  = `PRC_SEQ_PDN_CYC,
    parameter STEP_CYC = `PRC_SEQ_STEP_CYC
) (
    input  wire clk,
    input  wire sys_rst,
    output reg  synth_pdn_reg,
    output reg  rx_ana_reg,
    output reg  tx_dig_reg,
    output reg  rx_dig_reg,
    output reg  busy_reg
);
    localparam [2:0] ST_PDN  = 3'h0;
    localparam [2:0] ST_TX   = 3'h1;
    localparam [2:0] ST_ANA  = 3'h2;
    localparam [2:0] ST_RX   = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;
    reg [2:0]  state_reg;   // Sequence step
    reg [31:0] cnt_reg;     // Cycles spent in step
    // R1: restart sequence on every management reset
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg     <= ST_PDN;
            cnt_reg       <= 32'h00000000;
            synth_pdn_reg <= 1'b1;
            rx_ana_reg    <= 1'b1;
            tx_dig_reg    <= 1'b1;
            rx_dig_reg    <= 1'b1;
            busy_reg      <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            case (state_reg)
                // Synthesizer held down its full time
                ST_PDN: begin
                    if (cnt_reg >= PDN_CYC - 1) begin
                        synth_pdn_reg <= 1'b0;
                        cnt_reg       <= 32'h00000000;
                        state_reg     <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (cnt_reg >= STEP_CYC - 1) begin
                        tx_dig_reg <= 1'b0;
                        cnt_reg    <= 32'h00000000;
                        state_reg  <= ST_ANA;
                    end
                end
                ST_ANA: begin
                    if (cnt_reg >= STEP_CYC - 1) begin
                        rx_ana_reg <= 1'b0;
                        cnt_reg    <= 32'h00000000;
                        state_reg  <= ST_RX;
                    end
                end
                ST_RX: begin
                    if (cnt_reg >= STEP_CYC - 1) begin
                        rx_dig_reg <= 1'b0;
                        busy_reg   <= 1'b0;
                        state_reg  <= ST_DONE;
                    end
                end
                // Idle; counter frozen
                ST_DONE: begin
                    cnt_reg <= cnt_reg;
                end
                default: begin
                    state_reg <= ST_PDN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verilog/prc_csr.v ----
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
// Management register bank for a multi-channel transceiver PHY
module prc_csr #(
    parameter NUM_CH   = 4,
    parameter NUM_SEL  = 4,
    parameter SEL_W    = 2,
    parameter BONDED   = 0,
    parameter PDN_CYC  = `PRC_SEQ_PDN_CYC,
    parameter STEP_CYC = `PRC_SEQ_STEP_CYC
) (
    input  wire                        clk,
    input  wire                        sys_rst,
    input  wire [8:0]                  mgmt_address,
    input  wire [31:0]                 mgmt_writedata,
    input  wire                        mgmt_write,
    input  wire                        mgmt_read,
    output reg  [31:0]                 mgmt_readdata,
    output reg                         mgmt_waitrequest,
    input  wire [NUM_CH-1:0]           channel_reset_mask,
    input  wire [NUM_CH-1:0]           rx_sig_detect,
    input  wire [NUM_CH-1:0]           cdr_locked_data,
    input  wire [NUM_CH-1:0]           cdr_locked_ref,
    input  wire [NUM_SEL*5-1:0]        rx_slip_count,
    input  wire [NUM_SEL-1:0]          rx_fifo_err,
    input  wire [NUM_SEL-1:0]          tx_fifo_err,
    output wire [NUM_CH-1:0]           rx_digital_reset,
    output wire [NUM_CH-1:0]           rx_analog_reset,
    output wire [NUM_CH-1:0]           tx_digital_reset,
    output reg                         tx_synth_powerdown,
    output reg  [NUM_CH-1:0]           serial_loopback,
    output reg  [NUM_CH-1:0]           cdr_lock_to_data,
    output reg  [NUM_CH-1:0]           cdr_lock_to_ref,
    output reg  [SEL_W-1:0]            coding_sel,
    output reg                         coding_sel_is_group
);
    reg  [`PRC_MAN_RESET_W-1:0] man_reset_reg;   // Manual reset bits
    reg  [NUM_CH-1:0]           loopback_reg;    // Loopback enables
    reg  [NUM_CH-1:0]           force_data_reg;  // Force lock to data
    reg  [NUM_CH-1:0]           force_ref_reg;   // Force lock to reference
    reg  [SEL_W-1:0]            sel_reg;         // Lane or group selector
    reg  [31:0]                 rdata_next;      // Read mux output
    reg  [4:0]                  slip_sel;        // Selected slip count
    reg                         rx_err_sel;      // Selected rx FIFO error
    reg                         tx_err_sel;      // Selected tx FIFO error
    wire                        seq_pdn;
    wire                        seq_rx_ana;
    wire                        seq_tx_dig;
    wire                        seq_rx_dig;
    wire                        seq_busy;
    integer                     i;

    // Automatic power-on sequence
    prc_reset_seq #(
        .PDN_CYC  (PDN_CYC),
        .STEP_CYC (STEP_CYC)
    ) u_seq (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .synth_pdn_reg (seq_pdn),
        .rx_ana_reg    (seq_rx_ana),
        .tx_dig_reg    (seq_tx_dig),
        .rx_dig_reg    (seq_rx_dig),
        .busy_reg      (seq_busy)
    );

    // Per-channel reset gating
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            // R19: mask comes straight from the channel_reset_mask input, not a register
            prc_chan_gate u_gate (
                .clk            (clk),
                .sys_rst        (sys_rst),
                .mask_bit       (channel_reset_mask[g]),
                .man_rx_dig     (man_reset_reg[`PRC_BIT_RX_DIGITAL]),
                .man_rx_ana     (man_reset_reg[`PRC_BIT_RX_ANALOG]),
                .man_tx_dig     (man_reset_reg[`PRC_BIT_TX_DIGITAL]),
                .seq_rx_dig     (seq_rx_dig),
                .seq_rx_ana     (seq_rx_ana),
                .seq_tx_dig     (seq_tx_dig),
                .rx_dig_rst_reg (rx_digital_reset[g]),
                .rx_ana_rst_reg (rx_analog_reset[g]),
                .tx_dig_rst_reg (tx_digital_reset[g])
            );
        end
    endgenerate

    // Register writes; one-cycle wait handled below
    always @(posedge clk) begin
        if (sys_rst) begin
            man_reset_reg  <= `PRC_MAN_RESET_RST;
            loopback_reg   <= {NUM_CH{1'b0}};
            force_data_reg <= {NUM_CH{1'b0}};
            force_ref_reg  <= {NUM_CH{1'b0}};
            sel_reg        <= {SEL_W{1'b0}};
        end else if (mgmt_write && !mgmt_waitrequest) begin
            case (mgmt_address)
                // R2: upper bits dropped, no side effects
                `PRC_ADDR_MAN_RESET: begin
                    man_reset_reg <= mgmt_writedata[`PRC_MAN_RESET_W-1:0];
                end
                // R8: loopback per channel
                `PRC_ADDR_LOOPBACK: begin
                    loopback_reg <= mgmt_writedata[NUM_CH-1:0];
                end
                // R10: force data lock
                `PRC_ADDR_FORCE_DATA: begin
                    force_data_reg <= mgmt_writedata[NUM_CH-1:0];
                end
                // R11: force reference lock
                `PRC_ADDR_FORCE_REF: begin
                    force_ref_reg <= mgmt_writedata[NUM_CH-1:0];
                end
                // R14: selector for indirect coding access
                `PRC_ADDR_LANE_SEL: begin
                    sel_reg <= mgmt_writedata[SEL_W-1:0];
                end
                // Read-only and unmapped: writes ignored
                default: begin
                    man_reset_reg <= man_reset_reg;
                end
            endcase
        end
    end

    // R14: steer coding status through the selector
    always @* begin
        slip_sel   = 5'h00;
        rx_err_sel = 1'b0;
        tx_err_sel = 1'b0;
        for (i = 0; i < NUM_SEL; i = i + 1) begin
            if (sel_reg == i[SEL_W-1:0]) begin
                slip_sel   = rx_slip_count[i*5 +: 5];
                rx_err_sel = rx_fifo_err[i];
                tx_err_sel = tx_fifo_err[i];
            end
        end
    end

    // Read mux; unused bits and unmapped addresses read zero
    always @* begin
        rdata_next = 32'h00000000;
        case (mgmt_address)
            `PRC_ADDR_MAN_RESET: begin
                rdata_next[`PRC_MAN_RESET_W-1:0] = man_reset_reg;
            end
            `PRC_ADDR_LOOPBACK: begin
                rdata_next[NUM_CH-1:0] = loopback_reg;
            end
            // R9: signal present
            `PRC_ADDR_SIG_PRESENT: begin
                rdata_next[NUM_CH-1:0] = rx_sig_detect;
            end
            `PRC_ADDR_FORCE_DATA: begin
                rdata_next[NUM_CH-1:0] = force_data_reg;
            end
            `PRC_ADDR_FORCE_REF: begin
                rdata_next[NUM_CH-1:0] = force_ref_reg;
            end
            // R12: locked to data
            `PRC_ADDR_DATA_LOCKED: begin
                rdata_next[NUM_CH-1:0] = cdr_locked_data;
            end
            // R13: locked to reference
            `PRC_ADDR_REF_LOCKED: begin
                rdata_next[NUM_CH-1:0] = cdr_locked_ref;
            end
            // R15: same bits, meaning set by bonding
            `PRC_ADDR_LANE_SEL: begin
                rdata_next[SEL_W-1:0] = sel_reg;
            end
            // R16: slip count field
            `PRC_ADDR_RX_CODING: begin
                rdata_next[`PRC_SLIP_LSB +: `PRC_SLIP_W] = slip_sel;
                // R17: receive FIFO error
                rdata_next[`PRC_FIFO_ERR_BIT] = rx_err_sel;
            end
            // R18: transmit FIFO error
            `PRC_ADDR_TX_CODING: begin
                rdata_next[`PRC_FIFO_ERR_BIT] = tx_err_sel;
            end
            // R21: unmapped reads zero
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // Read data registered; waitrequest stalls the first cycle of any access
    // Writes need the low cycle too, or an idle-high waitrequest would refuse them all
    always @(posedge clk) begin
        if (sys_rst) begin
            mgmt_readdata    <= 32'h00000000;
            mgmt_waitrequest <= 1'b1;
        end else if ((mgmt_read || mgmt_write) && mgmt_waitrequest) begin
            // Read data only; a write lands on the following edge
            if (mgmt_read) begin
                mgmt_readdata <= rdata_next;
            end
            mgmt_waitrequest <= 1'b0;
        end else begin
            mgmt_waitrequest <= 1'b1;
        end
    end

    // Control outputs from flops, one cycle behind the registers
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_synth_powerdown  <= 1'b1;
            serial_loopback     <= {NUM_CH{1'b0}};
            cdr_lock_to_data    <= {NUM_CH{1'b0}};
            cdr_lock_to_ref     <= {NUM_CH{1'b0}};
            coding_sel          <= {SEL_W{1'b0}};
            coding_sel_is_group <= 1'b0;
        end else begin
            // R6: manual or automatic power-down
            tx_synth_powerdown  <= seq_pdn | man_reset_reg[`PRC_BIT_SYNTH_PDN];
            serial_loopback     <= loopback_reg;
            cdr_lock_to_data    <= force_data_reg;
            cdr_lock_to_ref     <= force_ref_reg;
            coding_sel          <= sel_reg;
            // R15: group numbering when bonded, once the reset sequence is done
            coding_sel_is_group <= (BONDED != 0) & ~seq_busy;
        end
    end
endmodule
`default_nettype wire

// ---- test/prc_csr_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
// Pin-level watcher for the register bank
module prc_csr_props #(
    parameter NUM_CH  = 4,
    parameter NUM_SEL = 4,
    parameter SEL_W   = 2,
    parameter BONDED  = 0
) (
    input wire                 clk,
    input wire                 sys_rst,
    input wire [8:0]           mgmt_address,
    input wire [31:0]          mgmt_writedata,
    input wire                 mgmt_write,
    input wire                 mgmt_read,
    input wire [31:0]          mgmt_readdata,
    input wire                 mgmt_waitrequest,
    input wire [NUM_CH-1:0]    channel_reset_mask,
    input wire [NUM_CH-1:0]    rx_sig_detect,
    input wire [NUM_CH-1:0]    cdr_locked_data,
    input wire [NUM_CH-1:0]    cdr_locked_ref,
    input wire [NUM_SEL*5-1:0] rx_slip_count,
    input wire [NUM_SEL-1:0]   rx_fifo_err,
    input wire [NUM_SEL-1:0]   tx_fifo_err,
    input wire [NUM_CH-1:0]    rx_digital_reset,
    input wire [NUM_CH-1:0]    rx_analog_reset,
    input wire [NUM_CH-1:0]    tx_digital_reset,
    input wire                 tx_synth_powerdown,
    input wire [NUM_CH-1:0]    serial_loopback,
    input wire [NUM_CH-1:0]    cdr_lock_to_data,
    input wire [NUM_CH-1:0]    cdr_lock_to_ref,
    input wire [SEL_W-1:0]     coding_sel,
    input wire                 coding_sel_is_group
);
    // Accepted write, taken read
    wire        wr_ok = mgmt_write && !mgmt_waitrequest;
    wire        rd_go = mgmt_read && mgmt_waitrequest;
    wire        man_w = wr_ok && mgmt_address == `PRC_ADDR_MAN_RESET;
    // Selected lane words; only valid while the selector is in range
    wire [31:0] rx_exp = {26'h0, rx_slip_count[coding_sel*5 +: 5], rx_fifo_err[coding_sel]};
    wire [31:0] tx_exp = {31'h0, tx_fifo_err[coding_sel]};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_reset_release: assert property ($fell(sys_rst) |->
        ((&rx_digital_reset) && (&rx_analog_reset) && (&tx_digital_reset))
        ##0 tx_synth_powerdown [*8]) else $error("reset outputs dropped early");
    a_read_answer: assert property (rd_go |=> !mgmt_waitrequest ##1 mgmt_waitrequest)
        else $error("read answer timing wrong");
    a_loopback_wr: assert property (wr_ok && mgmt_address == `PRC_ADDR_LOOPBACK
        |-> ##2 serial_loopback == $past(mgmt_writedata[NUM_CH-1:0], 2))
        else $error("loopback");
    a_data_lock_wr: assert property (wr_ok && mgmt_address == `PRC_ADDR_FORCE_DATA
        |-> ##2 cdr_lock_to_data == $past(mgmt_writedata[NUM_CH-1:0], 2))
        else $error("data lock");
    a_ref_lock_wr: assert property (wr_ok && mgmt_address == `PRC_ADDR_FORCE_REF
        |-> ##2 cdr_lock_to_ref == $past(mgmt_writedata[NUM_CH-1:0], 2))
        else $error("ref lock");
    a_lane_sel_wr: assert property (wr_ok && mgmt_address == `PRC_ADDR_LANE_SEL
        |-> ##2 coding_sel == $past(mgmt_writedata[SEL_W-1:0], 2))
        else $error("selector");
    a_synth_pdn_set: assert property (man_w && mgmt_writedata[0] |-> ##2 tx_synth_powerdown)
        else $error("synth not powered down");
    a_rx_dig_set: assert property (man_w && mgmt_writedata[3] |-> ##2
        ((rx_digital_reset & channel_reset_mask) == channel_reset_mask)) else $error("rx dig");
    a_rx_ana_set: assert property (man_w && mgmt_writedata[2] |-> ##2
        ((rx_analog_reset & channel_reset_mask) == channel_reset_mask)) else $error("rx ana");
    a_tx_dig_set: assert property (man_w && mgmt_writedata[1] |-> ##2
        ((tx_digital_reset & channel_reset_mask) == channel_reset_mask)) else $error("tx dig");
    a_sig_present_rd: assert property (rd_go && mgmt_address == `PRC_ADDR_SIG_PRESENT
        |=> mgmt_readdata == 32'($past(rx_sig_detect))) else $error("signal present");
    a_rx_coding_rd: assert property (rd_go && mgmt_address == `PRC_ADDR_RX_CODING
        |=> mgmt_readdata == $past(rx_exp)) else $error("rx coding word");
    a_tx_coding_rd: assert property (rd_go && mgmt_address == `PRC_ADDR_TX_CODING
        |=> mgmt_readdata == $past(tx_exp)) else $error("tx coding word");
endmodule
bind prc_csr prc_csr_props #(.NUM_CH(NUM_CH), .NUM_SEL(NUM_SEL), .SEL_W(SEL_W), .BONDED(BONDED))
    u_props (.clk(clk), .sys_rst(sys_rst), .mgmt_address(mgmt_address),
    .mgmt_writedata(mgmt_writedata), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
    .mgmt_readdata(mgmt_readdata), .mgmt_waitrequest(mgmt_waitrequest),
    .channel_reset_mask(channel_reset_mask), .rx_sig_detect(rx_sig_detect),
    .cdr_locked_data(cdr_locked_data), .cdr_locked_ref(cdr_locked_ref),
    .rx_slip_count(rx_slip_count), .rx_fifo_err(rx_fifo_err), .tx_fifo_err(tx_fifo_err),
    .rx_digital_reset(rx_digital_reset), .rx_analog_reset(rx_analog_reset),
    .tx_digital_reset(tx_digital_reset), .tx_synth_powerdown(tx_synth_powerdown),
    .serial_loopback(serial_loopback), .cdr_lock_to_data(cdr_lock_to_data),
    .cdr_lock_to_ref(cdr_lock_to_ref), .coding_sel(coding_sel),
    .coding_sel_is_group(coding_sel_is_group));
`default_nettype wire

// ---- test/prc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Management host: one word per bus cycle, held until waitrequest drops
module prc_host (
    input  wire        clk,
    input  wire        mgmt_waitrequest,
    input  wire [31:0] mgmt_readdata,
    output reg  [8:0]  mgmt_address,
    output reg  [31:0] mgmt_writedata,
    output reg         mgmt_write,
    output reg         mgmt_read
);
    reg [7:0] stalls = 8'h0;  // Cycles that never completed
    // Idle bus shows no stale request
    initial begin
        mgmt_address = 9'h1FF;
        mgmt_writedata = 32'h0;
        mgmt_write = 1'b0;
        mgmt_read = 1'b0;
    end
    // One bus cycle; a read first waits for the take edge, then the answer
    task xfer(input rd, input [8:0] a, input [31:0] d, output [31:0] q);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            mgmt_address <= a;
            mgmt_writedata <= d;
            mgmt_write <= !rd;
            mgmt_read <= rd;
            @(posedge clk);
            while (rd && mgmt_waitrequest !== 1'b1 && n < 8) begin
                @(posedge clk);
                n = n + 1;
            end
            if (rd) @(posedge clk);
            while (mgmt_waitrequest !== 1'b0 && n < 8) begin
                @(posedge clk);
                n = n + 1;
            end
            q = mgmt_readdata;
            if (n >= 8) stalls = stalls + 8'h1;
            // Strobes drop; released address and data show the inverse, never the last value
            mgmt_write <= 1'b0;
            mgmt_read <= 1'b0;
            mgmt_address <= ~a;
            mgmt_writedata <= ~d;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/prc_csr_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin \
    fails = fails + 1; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module prc_csr_tb_top;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [3:0]  mask = 4'h6;        // Only lanes 1 and 2 take manual resets
    reg  [3:0]  sig = 4'hA;
    reg  [3:0]  ldat = 4'h5;
    reg  [3:0]  lref = 4'h3;
    reg  [19:0] slip = 20'hFA5C3;   // Four 5-bit slip counts
    reg  [3:0]  rxe = 4'h5;
    reg  [3:0]  txe = 4'hA;
    wire [8:0]  addr;
    wire [31:0] wdata, rdata;
    wire        wr_en, rd_en, wait_req, pdn, is_grp;
    wire [3:0]  rxd, rxa, txd, lpb, ltd, reference_lock_state;
    wire [1:0]  sel;
    reg  [31:0] q;
    integer     fails = 0, comparisons = 0, cycles = 0, i;
    always #10 clk = ~clk;
    prc_host u_host (.clk(clk), .mgmt_waitrequest(wait_req), .mgmt_readdata(rdata),
        .mgmt_address(addr), .mgmt_writedata(wdata), .mgmt_write(wr_en), .mgmt_read(rd_en));
    // Short sequence counts keep the run brief
    prc_csr #(.PDN_CYC(20), .STEP_CYC(4)) uut (.clk(clk), .sys_rst(sys_rst),
        .mgmt_address(addr), .mgmt_writedata(wdata), .mgmt_write(wr_en), .mgmt_read(rd_en),
        .mgmt_readdata(rdata), .mgmt_waitrequest(wait_req), .channel_reset_mask(mask),
        .rx_sig_detect(sig), .cdr_locked_data(ldat), .cdr_locked_ref(lref),
        .rx_slip_count(slip), .rx_fifo_err(rxe), .tx_fifo_err(txe), .rx_digital_reset(rxd),
        .rx_analog_reset(rxa), .tx_digital_reset(txd), .tx_synth_powerdown(pdn),
        .serial_loopback(lpb), .cdr_lock_to_data(ltd), .cdr_lock_to_ref(reference_lock_state),
        .coding_sel(sel), .coding_sel_is_group(is_grp));
    task results;
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input [8:0] a, input [31:0] d);
        u_host.xfer(1'b0, a, d, q);
    endtask
    task rd_chk(input [8:0] a, input [31:0] e);
        begin
            u_host.xfer(1'b1, a, 32'h0, q);
            `CHK(q, e)
        end
    endtask
    // Hang guard, a little above the power-down wait
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            results;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (40) @(posedge clk);                       // Sequence: 20 + 3 steps of 4
        `CHK({pdn, rxd, rxa, txd}, 13'h0)
        wr(`PRC_ADDR_LOOPBACK, 32'hFFFFFFF3);
        wr(`PRC_ADDR_FORCE_DATA, 32'hFFFFFFF8);
        wr(`PRC_ADDR_FORCE_REF, 32'h0000000D);
        repeat (2) @(posedge clk);
        `CHK({lpb, ltd, reference_lock_state}, 12'h38D)
        rd_chk(`PRC_ADDR_LOOPBACK, 32'h3);
        rd_chk(`PRC_ADDR_FORCE_DATA, 32'h8);
        rd_chk(`PRC_ADDR_FORCE_REF, 32'hD);
        wr(`PRC_ADDR_SIG_PRESENT, 32'hFFFFFFFF);
        rd_chk(`PRC_ADDR_SIG_PRESENT, 32'hA);
        rd_chk(`PRC_ADDR_DATA_LOCKED, 32'h5);
        rd_chk(`PRC_ADDR_REF_LOCKED, 32'h3);
        rd_chk(9'h1FF, 32'h0);
        // Each manual bit alone, upper bits written as zero
        for (i = 1; i < 4; i = i + 1) begin
            wr(`PRC_ADDR_MAN_RESET, 32'h1 << i);
            repeat (3) @(posedge clk);
            `CHK({rxd, rxa, txd}, 12'h6 << (4 * (i - 1)))
            rd_chk(`PRC_ADDR_MAN_RESET, 32'h1 << i);
        end
        wr(`PRC_ADDR_MAN_RESET, 32'h0);
        repeat (3) @(posedge clk);
        `CHK({rxd, rxa, txd}, 12'h0)
        wr(`PRC_ADDR_MAN_RESET, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(pdn, 1'b1)
        repeat (50000) @(posedge clk);
        wr(`PRC_ADDR_MAN_RESET, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(pdn, 1'b0)
        for (i = 0; i < 4; i = i + 1) begin
            wr(`PRC_ADDR_LANE_SEL, i);
            repeat (2) @(posedge clk);
            `CHK(sel, i[1:0])
            `CHK(is_grp, 1'b0)
            rd_chk(`PRC_ADDR_RX_CODING, {26'h0, slip[i*5 +: 5], rxe[i]});
            rd_chk(`PRC_ADDR_TX_CODING, {31'h0, txe[i]});
        end
        // Second reset in mid-run
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({pdn, rxd, rxa, txd, lpb}, 17'h1FFF0)
        sys_rst <= 1'b0;
        repeat (40) @(posedge clk);
        rd_chk(`PRC_ADDR_LOOPBACK, 32'h0);
        `CHK(u_host.stalls, 8'h0)
        results;
    end
endmodule
`default_nettype wire
